/* File: hw/pmc_pkg.sv */
// Purpose: Shared constants and types for the power mode clock manager
// Assumes: Single core clock of 250 MHz; oscillators arrive as sampled levels
// Notes:   Microsecond timing figures are held in their own unit and converted here
package pmc_pkg;
    localparam int unsigned CORE_CLK_MHZ      = 250;
    localparam int unsigned PLL_LOCK_US       = 2000;                   // 2 ms
    localparam int unsigned PLL_LOCK_CYC      = PLL_LOCK_US * CORE_CLK_MHZ;
    localparam int unsigned POWER_UP_TIMER_US           = 65000;                  // Plain default
    localparam int unsigned POWER_UP_TIMER_CYC          = POWER_UP_TIMER_US * CORE_CLK_MHZ;
    localparam int unsigned CSD_US            = 10;                     // Plain default
    localparam int unsigned CSD_CYC           = CSD_US * CORE_CLK_MHZ;
    localparam int unsigned OST_OSC_CYCLES    = 1024;
    localparam int unsigned OLD_SRC_EDGES     = 2;
    localparam int unsigned NEW_SRC_EDGES     = 3;
    localparam int unsigned TMR_W             = 32;
    localparam int unsigned OST_W             = 11;

    // Clock-choice bit encodings
    localparam logic [1:0] CHOICE_PRIMARY     = 2'h0;
    localparam logic [1:0] CHOICE_SECONDARY   = 2'h1;
    localparam int unsigned CHOICE_INT_BIT    = 1;

    // Primary source configuration codes
    typedef enum logic [3:0] {
        PMC_LOW_POWER_CRYSTAL        = 4'h0,
        PMC_STANDARD_CRYSTAL         = 4'h1,
        PMC_HIGH_SPEED_CRYSTAL       = 4'h2,
        PMC_RESISTOR_CAPACITOR_OSC   = 4'h3,
        PMC_EXTERNAL_CLOCK_IN_MODE   = 4'h4,
        PMC_EXTERNAL_CLOCK_IO_MODE   = 4'h5,
        PMC_MULTIPLIED_CRYSTAL_MODE  = 4'h6,
        PMC_RESISTOR_CAPACITOR_IO    = 4'h7,
        PMC_INTERNAL_BOTH_PINS_IO    = 4'h8,
        PMC_INTERNAL_WITH_CLKOUT     = 4'h9
    } pmc_src_e;

    // Source selected on the glitch-free mux
    typedef enum logic [1:0] {
        PMC_SEL_PRIMARY   = 2'h0,
        PMC_SEL_SECONDARY = 2'h1,
        PMC_SEL_FAST_INT  = 2'h2,
        PMC_SEL_SLOW_INT  = 2'h3
    } pmc_sel_e;

    // Oscillator enables
    typedef struct packed {
        logic primaryEn;
        logic secondaryEn;
        logic slowIntEn;
        logic fastIntEn;
    } pmc_osc_en_s;

    // Pin state while the part sleeps, and the clock-out role while awake
    typedef struct packed {
        logic inPinIsPortA7;
        logic outPinIsPortA6;
        logic outPinForceLow;
        logic outPinClkDiv4;
    } pmc_pin_s;

    // True when the clock-choice bits pick the internal block
    function automatic logic pmc_is_internal(input logic [1:0] choice);
        return choice[CHOICE_INT_BIT];
    endfunction

    // True for crystal modes that need the start-up count
    function automatic logic pmc_needs_ost(input pmc_src_e src);
        return (src == PMC_LOW_POWER_CRYSTAL) || (src == PMC_STANDARD_CRYSTAL) ||
               (src == PMC_HIGH_SPEED_CRYSTAL) || (src == PMC_MULTIPLIED_CRYSTAL_MODE);
    endfunction
endpackage

/* File: hw/pmc_delay_count.sv */
// Purpose: Down counter that signals when a programmed delay has elapsed
// Assumes: Load is a single-cycle pulse; count runs while run is high
// Notes:   Used for power-up timer, PLL lock and code-start delays
`timescale 1ns/100ps
module pmc_delay_count
    import pmc_pkg::*;
#(
    parameter int unsigned WIDTH = TMR_W
) (
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    input  wire logic             run,
    output logic                  done
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic             done_r;
    logic             done_nxt;

    // Next count; done rises on the cycle the count reaches zero
    always_comb begin
        count_nxt = count_r;
        done_nxt  = done_r;
        if (load) begin
            count_nxt = loadValue;
            done_nxt  = (loadValue == '0);
        end else if (run && !done_r) begin
            count_nxt = count_r - {{(WIDTH-1){1'b0}}, 1'b1};
            done_nxt  = (count_r <= {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    // Registers only
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= '0;
            done_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            done_r  <= done_nxt;
        end
    end

    assign done = done_r;
endmodule // pmc_delay_count

/* File: hw/pmc_glitch_free_mux.sv */
// Purpose: Pause-and-handover controller for the device clock source
// Assumes: Source clocks arrive as rise pulses sampled on core_clk
// Notes:   Handover waits out old-source edges, then new-source edges
`timescale 1ns/100ps
module pmc_glitch_free_mux
    import pmc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  pmc_sel_e         reqSel,
    input  wire logic [3:0]  srcRise,
    input  wire logic [3:0]  srcRunning,
    output pmc_sel_e         activeSel,
    output logic             clockPaused
);
    typedef enum {PMC_MUX_IDLE, PMC_MUX_OLD, PMC_MUX_NEW} pmc_mux_e;

    pmc_mux_e  state_r;
    pmc_mux_e  state_nxt;
    pmc_sel_e  active_r;
    pmc_sel_e  active_nxt;
    pmc_sel_e  target_r;
    pmc_sel_e  target_nxt;
    logic [2:0] edges_r;
    logic [2:0] edges_nxt;
    logic       paused_r;
    logic       paused_nxt;

    // Handover sequence; a target that is not running is never taken
    always_comb begin
        state_nxt  = state_r;
        active_nxt = active_r;
        target_nxt = target_r;
        edges_nxt  = edges_r;
        paused_nxt = paused_r;
        case (state_r)
            PMC_MUX_IDLE: begin
                if (reqSel != active_r && srcRunning[reqSel]) begin
                    target_nxt = reqSel;
                    edges_nxt  = '0;
                    paused_nxt = 1'b1;
                    state_nxt  = PMC_MUX_OLD;
                end
            end
            PMC_MUX_OLD: begin
                // Gated from entry, then old-source edges are waited out so no runt pulse escapes
                if (srcRise[active_r]) begin
                    edges_nxt = edges_r + 3'h1;
                    if (edges_r == 3'(OLD_SRC_EDGES - 1)) begin
                        edges_nxt = '0;
                        state_nxt = PMC_MUX_NEW;
                    end
                end
            end
            PMC_MUX_NEW: begin
                if (srcRise[target_r]) begin
                    edges_nxt = edges_r + 3'h1;
                    if (edges_r == 3'(NEW_SRC_EDGES - 1)) begin
                        active_nxt = target_r;
                        paused_nxt = 1'b0;
                        state_nxt  = PMC_MUX_IDLE;
                    end
                end
            end
            default: state_nxt = PMC_MUX_IDLE;
        endcase
    end

    // Registers only
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r  <= PMC_MUX_IDLE;
            active_r <= PMC_SEL_PRIMARY;
            target_r <= PMC_SEL_PRIMARY;
            edges_r  <= '0;
            paused_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            active_r <= active_nxt;
            target_r <= target_nxt;
            edges_r  <= edges_nxt;
            paused_r <= paused_nxt;
        end
    end

    assign activeSel   = active_r;
    assign clockPaused = paused_r;
endmodule // pmc_glitch_free_mux

/* File: hw/pmc_power_mode_clock_manager.sv */
// What this block does
// - Main-oscillator idle keeps primary oscillator running
// - Other low-power modes stop the input-pin oscillator
// - Timer-oscillator modes clock from the secondary oscillator
// - Secondary oscillator may run for counter units
// - Slow internal source usable directly, always enableable
// - Fast internal source drives only via postscaler
// - Slow source direct disables fast source output
// - Sleep stops unneeded sources, CPU and peripheral clocks
// - Slow source runs in Sleep with watchdog
// - Power-up timer active only when enable bit 0
// - Crystal modes wait 1024 oscillator cycles
// - Multiplied crystal adds 2 ms lock wait
// - Code-start delay runs alongside other delays
// - Sleep drives output pin low in clock-out modes
// - Sleep pins become port A bit 6 in I/O modes, bit 7 in both-pins mode
// - Seven modes: run, idle, sleep categories
// - Halt bit steers CPU, choice bits pick source
// - Choice 00 primary, 01 secondary, 1x internal
// - Primary source follows the primary configuration code
// - New choice switches after the edge pause if source runs
// - Sleep instruction enters Sleep or Idle by halt bit
// - Switch pauses two old, three new edges
// - Choice 01 without secondary enable is refused
// - Entering Sleep clears all source status flags
//
// Purpose: Power-managed mode selection, clock gating and power-up sequencing
// Assumes: Oscillator signals are asynchronous levels; a wake event ends Sleep and Idle
// Notes:   Clocks are modelled as sampled enables; analog oscillators live elsewhere
`timescale 1ns/100ps
module pmc_power_mode_clock_manager
    import pmc_pkg::*;
#(
    parameter int unsigned POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_CYC,
    parameter int unsigned PLL_CYCLES  = PLL_LOCK_CYC,
    parameter int unsigned CSD_CYCLES  = CSD_CYC,
    parameter int unsigned OST_COUNT   = OST_OSC_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  pmc_src_e        primary_source_config,
    input  wire logic       power_up_timer_enable_n,
    input  wire logic       cpu_halt_on_sleep,
    input  wire logic [1:0] clock_choice_bits,
    input  wire logic       fastIntPostscaleOn,
    input  wire logic       secondary_oscillator_enable,
    input  wire logic       counterUnitsNeedSecondary,
    input  wire logic       watchdogEnable,
    input  wire logic       slowIntFeatureReq,
    input  wire logic       sleepInstr,
    input  wire logic       wakeEvent,
    input  wire logic       primaryOscIn,
    input  wire logic       secondaryOscIn,
    input  wire logic       slowIntOscIn,
    input  wire logic       fastIntOscIn,
    output pmc_osc_en_s     oscEnable,
    output pmc_sel_e        deviceClockSel,
    output logic            fastViaPostscaler,
    output logic            cpuClockEn,
    output logic            periphClockEn,
    output logic            internalResetN,
    output logic            primary_ready_flag,
    output logic            secondaryRunFlag,
    output logic            fastStableFlag,
    output pmc_pin_s        sleepPins,
    output logic            inSleep,
    output logic            inIdle
);
    typedef enum {PMC_RST, PMC_RUN, PMC_IDLE, PMC_SLEEP} pmc_mode_e;

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator input synchronisers: three stages, change taken when 2 and 3 agree
    logic [3:0] syncA_r;
    logic [3:0] syncB_r;
    logic [3:0] syncC_r;
    logic [3:0] oscLvl_r;
    logic [3:0] oscLvl_nxt;
    logic [3:0] srcRise;

    always_comb begin
        oscLvl_nxt = oscLvl_r;
        for (int i = 0; i < 4; i++) begin
            if (syncB_r[i] == syncC_r[i]) begin
                oscLvl_nxt[i] = syncC_r[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            syncA_r  <= '0;
            syncB_r  <= '0;
            syncC_r  <= '0;
            oscLvl_r <= '0;
        end else begin
            syncA_r  <= {slowIntOscIn, fastIntOscIn, secondaryOscIn, primaryOscIn};
            syncB_r  <= syncA_r;
            syncC_r  <= syncB_r;
            oscLvl_r <= oscLvl_nxt;
        end
    end

    // Bit order follows pmc_sel_e: primary, secondary, fast, slow
    logic [3:0] lvlBySel;
    logic [3:0] lvlBySelD_r;
    assign lvlBySel = {oscLvl_r[3], oscLvl_r[2], oscLvl_r[1], oscLvl_r[0]};
    assign srcRise  = lvlBySel & ~lvlBySelD_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lvlBySelD_r <= '0;
        end else begin
            lvlBySelD_r <= lvlBySel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-up delays
    logic       needOst;
    logic       isPll;
    logic       ostDone_r;
    logic       ostDone_nxt;
    logic [OST_W-1:0] ostCnt_r;
    logic [OST_W-1:0] ostCnt_nxt;
    logic       startLoad_r;
    logic       pwrtDone;
    logic       pllDone;
    logic       csdDone;
    logic       primaryStarting;

    assign needOst = pmc_needs_ost(primary_source_config);
    assign isPll   = (primary_source_config == PMC_MULTIPLIED_CRYSTAL_MODE);

    // Start-up count of primary oscillator edges; restarts when primary is re-enabled
    always_comb begin
        ostCnt_nxt  = ostCnt_r;
        ostDone_nxt = ostDone_r;
        if (!oscEnable.primaryEn) begin
            ostCnt_nxt  = '0;
            ostDone_nxt = !needOst;
        end else if (!needOst) begin
            ostDone_nxt = 1'b1;
        end else if (!ostDone_r && srcRise[PMC_SEL_PRIMARY]) begin
            ostCnt_nxt = ostCnt_r + OST_W'(1);
            if (ostCnt_r == OST_W'(OST_COUNT - 1)) begin
                ostDone_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ostCnt_r    <= '0;
            ostDone_r   <= 1'b0;
            startLoad_r <= 1'b1;
        end else begin
            ostCnt_r    <= ostCnt_nxt;
            ostDone_r   <= ostDone_nxt;
            startLoad_r <= 1'b0;
        end
    end

    // Power-up timer only when its enable bit is programmed low
    pmc_delay_count #(.WIDTH(TMR_W)) uPwrt (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .load      (startLoad_r),
        .loadValue (power_up_timer_enable_n ? '0 : TMR_W'(POWER_UP_TIMER_CYCLES)),
        .run       (1'b1),
        .done      (pwrtDone)
    );

    // PLL lock extension starts only after the start-up count
    pmc_delay_count #(.WIDTH(TMR_W)) uPll (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .load      (startLoad_r),
        .loadValue (isPll ? TMR_W'(PLL_CYCLES) : '0),
        .run       (ostDone_r),
        .done      (pllDone)
    );

    // Code-start delay counts from release alongside the others
    pmc_delay_count #(.WIDTH(TMR_W)) uCsd (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .load      (startLoad_r),
        .loadValue (TMR_W'(CSD_CYCLES)),
        .run       (1'b1),
        .done      (csdDone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode state and status flags
    pmc_mode_e mode_r;
    pmc_mode_e mode_nxt;
    logic      sleepFlagClr;
    logic      pri_r;
    logic      pri_nxt;
    pmc_sel_e  reqSel;
    pmc_sel_e  reqSel_r;
    pmc_sel_e  reqSel_nxt;
    logic      muxPaused;

    // Reset held until every delay is over; then sleep instruction picks the mode
    always_comb begin
        mode_nxt     = mode_r;
        sleepFlagClr = 1'b0;
        case (mode_r)
            PMC_RST: begin
                if (pwrtDone && ostDone_r && pllDone && csdDone) begin
                    mode_nxt = PMC_RUN;
                end
            end
            PMC_RUN: begin
                if (sleepInstr) begin
                    mode_nxt     = cpu_halt_on_sleep ? PMC_IDLE : PMC_SLEEP;
                    sleepFlagClr = !cpu_halt_on_sleep;
                end
            end
            PMC_IDLE: begin
                if (wakeEvent) begin
                    mode_nxt = PMC_RUN;
                end
            end
            PMC_SLEEP: begin
                sleepFlagClr = 1'b1;
                if (wakeEvent) begin
                    mode_nxt = PMC_RUN;
                end
            end
            default: mode_nxt = PMC_RST;
        endcase
    end

    // Requested source; choice 01 without the secondary enable keeps the old one
    always_comb begin
        reqSel_nxt = reqSel_r;
        if (pmc_is_internal(clock_choice_bits)) begin
            reqSel_nxt = fastIntPostscaleOn ? PMC_SEL_FAST_INT : PMC_SEL_SLOW_INT;
        end else if (clock_choice_bits == CHOICE_SECONDARY) begin
            if (secondary_oscillator_enable) begin
                reqSel_nxt = PMC_SEL_SECONDARY;
            end
        end else begin
            reqSel_nxt = PMC_SEL_PRIMARY;
        end
    end
    assign reqSel = reqSel_r;

    // Primary-ready flag: hardware set wins over the sleep clear
    always_comb begin
        pri_nxt = pri_r;
        if (sleepFlagClr) begin
            pri_nxt = 1'b0;
        end
        if (deviceClockSel == PMC_SEL_PRIMARY && ostDone_r && oscEnable.primaryEn
            && mode_r != PMC_SLEEP) begin
            pri_nxt = 1'b1;
        end else if (!ostDone_r || deviceClockSel != PMC_SEL_PRIMARY) begin
            pri_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r   <= PMC_RST;
            reqSel_r <= PMC_SEL_PRIMARY;
            pri_r    <= 1'b0;
        end else begin
            mode_r   <= mode_nxt;
            reqSel_r <= reqSel_nxt;
            pri_r    <= pri_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Glitch-free source handover
    pmc_glitch_free_mux uMux (
        .core_clk    (core_clk),
        .resetn      (resetn),
        .reqSel      (reqSel),
        .srcRise     (srcRise),
        .srcRunning  ({oscEnable.slowIntEn, oscEnable.fastIntEn,
                       oscEnable.secondaryEn, oscEnable.primaryEn}),
        .activeSel   (deviceClockSel),
        .clockPaused (muxPaused)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator enables and clock gates per mode
    logic sleeping;
    assign sleeping = (mode_r == PMC_SLEEP);

    always_comb begin
        // Primary runs in reset, run and idle only while it is the selected source
        oscEnable.primaryEn   = (mode_r == PMC_RST) ||
                                (!sleeping && (reqSel == PMC_SEL_PRIMARY ||
                                 deviceClockSel == PMC_SEL_PRIMARY));
        oscEnable.secondaryEn = secondary_oscillator_enable &&
                                (!sleeping || counterUnitsNeedSecondary);
        oscEnable.slowIntEn   = watchdogEnable || slowIntFeatureReq ||
                                (!sleeping && (reqSel == PMC_SEL_SLOW_INT ||
                                 deviceClockSel == PMC_SEL_SLOW_INT));
        oscEnable.fastIntEn   = !sleeping &&
                                (reqSel == PMC_SEL_FAST_INT ||
                                 deviceClockSel == PMC_SEL_FAST_INT);
    end

    // Run clocks both, idle peripherals only, sleep and reset neither
    assign cpuClockEn    = (mode_r == PMC_RUN) && !muxPaused;
    assign periphClockEn = (mode_r == PMC_RUN || mode_r == PMC_IDLE) && !muxPaused;
    assign internalResetN     = (mode_r != PMC_RST);
    assign primary_ready_flag = pri_r;
    assign secondaryRunFlag   = !sleeping && deviceClockSel == PMC_SEL_SECONDARY;
    assign fastStableFlag     = !sleeping && deviceClockSel == PMC_SEL_FAST_INT;
    assign fastViaPostscaler  = (deviceClockSel == PMC_SEL_FAST_INT);
    assign inSleep            = sleeping;
    assign inIdle             = (mode_r == PMC_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Pin roles during Sleep, and the divide-by-4 clock-out role outside it
    always_comb begin
        sleepPins.inPinIsPortA7  = sleeping &&
            primary_source_config == PMC_INTERNAL_BOTH_PINS_IO;
        sleepPins.outPinIsPortA6 = sleeping &&
            (primary_source_config == PMC_INTERNAL_BOTH_PINS_IO ||
             primary_source_config == PMC_RESISTOR_CAPACITOR_IO ||
             primary_source_config == PMC_EXTERNAL_CLOCK_IO_MODE);
        sleepPins.outPinForceLow = sleeping &&
            (primary_source_config == PMC_INTERNAL_WITH_CLKOUT ||
             primary_source_config == PMC_RESISTOR_CAPACITOR_OSC ||
             primary_source_config == PMC_EXTERNAL_CLOCK_IN_MODE);
        sleepPins.outPinClkDiv4  = !sleeping &&
            (primary_source_config == PMC_INTERNAL_WITH_CLKOUT ||
             primary_source_config == PMC_RESISTOR_CAPACITOR_OSC ||
             primary_source_config == PMC_EXTERNAL_CLOCK_IN_MODE);
    end
endmodule // pmc_power_mode_clock_manager

/* File: sim/pmc_osc_model.sv */
// Purpose: Oscillator sources seen by the clock manager
// Assumes: Each source divides core_clk and is slower than core_clk/4
// Notes:   A disabled source stands still low
`timescale 1ns/100ps
module pmc_osc_model
    import pmc_pkg::*;
(
    input  wire logic  core_clk,
    input  wire logic  resetn,
    input  pmc_osc_en_s oscEnable,
    output logic [3:0] osc
);
    logic [7:0] cnt;
    ////////////////////////////////////////////////////////////////
    // Primary toggles every 4, secondary 6, fast 5, slow 8 cycles
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 8'h00;
            osc <= 4'h0;
        end else begin
            cnt    <= cnt + 8'h01;
            osc[3] <= oscEnable.primaryEn   & (cnt % 8 < 4);
            osc[2] <= oscEnable.secondaryEn & (cnt % 12 < 6);
            osc[1] <= oscEnable.slowIntEn   & (cnt % 16 < 8);
            osc[0] <= oscEnable.fastIntEn   & (cnt % 10 < 5);
        end
    end
endmodule // pmc_osc_model

/* File: sim/pmc_checker.sv */
// Purpose: Port-level checks of mode entry and clock gating
// Assumes: One clock domain
// Notes:   Bound to the top module
`timescale 1ns/100ps
module pmc_checker
    import pmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cpu_halt_on_sleep,
    input wire logic watchdogEnable,
    input wire logic sleepInstr,
    input pmc_osc_en_s oscEnable,
    input pmc_sel_e  deviceClockSel,
    input wire logic cpuClockEn,
    input wire logic periphClockEn,
    input wire logic internalResetN,
    input wire logic primary_ready_flag,
    input wire logic inSleep,
    input wire logic inIdle
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Sleep instruction taken only in Run
    sequence sReq;
        sleepInstr && !inSleep && !inIdle && internalResetN;
    endsequence
    a_sleep_entry: assert property (sReq ##0 !cpu_halt_on_sleep |=> inSleep)
        else $error("sleep not entered");
    a_idle_entry: assert property (sReq ##0 cpu_halt_on_sleep |=> inIdle && periphClockEn)
        else $error("idle not entered");
    a_sleep_gates: assert property (inSleep |-> !cpuClockEn && !periphClockEn && !oscEnable.primaryEn)
        else $error("clock alive in sleep");
    a_wdt_slow_on: assert property (inSleep && watchdogEnable |-> oscEnable.slowIntEn)
        else $error("slow source off with watchdog");
    a_idle_primary: assert property (inIdle && deviceClockSel == PMC_SEL_PRIMARY |-> oscEnable.primaryEn)
        else $error("primary stopped in idle");
    a_slow_no_fast: assert property (deviceClockSel == PMC_SEL_SLOW_INT && !inSleep |-> !oscEnable.fastIntEn)
        else $error("fast output on");
    a_ready_clear: assert property ($rose(inSleep) |=> !primary_ready_flag)
        else $error("ready kept in sleep");
    a_reset_hold: assert property (!internalResetN |-> !cpuClockEn && !periphClockEn)
        else $error("clocks before reset end");
endmodule // pmc_checker
bind pmc_power_mode_clock_manager pmc_checker pmc_checker_i(.core_clk(core_clk), .resetn(resetn),
    .cpu_halt_on_sleep(cpu_halt_on_sleep), .watchdogEnable(watchdogEnable), .sleepInstr(sleepInstr),
    .oscEnable(oscEnable), .deviceClockSel(deviceClockSel), .cpuClockEn(cpuClockEn),
    .periphClockEn(periphClockEn), .internalResetN(internalResetN), .inSleep(inSleep),
    .primary_ready_flag(primary_ready_flag), .inIdle(inIdle));

/* File: sim/testbench.sv */
// Purpose: Mode entry, source switching and power-up sequencing tests
// Assumes: Shortened delay parameters; multiplied crystal primary
// Notes:   Inputs change on the falling edge
`timescale 1ns/100ps
module testbench
    import pmc_pkg::*;
;
    logic core_clk = 0, resetn = 0, halt = 0, secEn = 0, post = 0, sleepI = 0, wake = 0;
    logic [1:0] choice = 2'h0;
    logic [3:0] osc;
    logic cpuEn, perEn, rstOut, ready, inS, inI, fvp, secRun, fastOk;
    pmc_pin_s pins;
    pmc_osc_en_s oscEn;
    pmc_sel_e sel;
    int errors = 0, n_tests = 0, cyc;
    initial forever #2 core_clk = ~core_clk;
    pmc_osc_model pmc_osc_model_i(.core_clk(core_clk), .resetn(resetn), .oscEnable(oscEn), .osc(osc));
    pmc_power_mode_clock_manager #(.POWER_UP_TIMER_CYCLES(50), .PLL_CYCLES(40), .CSD_CYCLES(20),
        .OST_COUNT(16)) pmc_power_mode_clock_manager_i(.core_clk(core_clk), .resetn(resetn),
        .primary_source_config(PMC_MULTIPLIED_CRYSTAL_MODE), .power_up_timer_enable_n(1'b0),
        .cpu_halt_on_sleep(halt), .clock_choice_bits(choice), .fastIntPostscaleOn(post),
        .secondary_oscillator_enable(secEn), .counterUnitsNeedSecondary(1'b0),
        .watchdogEnable(1'b1), .slowIntFeatureReq(1'b0), .sleepInstr(sleepI), .wakeEvent(wake),
        .primaryOscIn(osc[3]), .secondaryOscIn(osc[2]), .slowIntOscIn(osc[1]),
        .fastIntOscIn(osc[0]), .oscEnable(oscEn), .deviceClockSel(sel), .fastViaPostscaler(fvp),
        .cpuClockEn(cpuEn), .periphClockEn(perEn), .internalResetN(rstOut),
        .primary_ready_flag(ready), .secondaryRunFlag(secRun), .fastStableFlag(fastOk),
        .sleepPins(pins),
        .inSleep(inS), .inIdle(inI));
    ////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [1:0] e, logic [1:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude;
        $display("errors=%0d checks=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Sleep instruction as a one-cycle pulse; mode seen one edge later
    task automatic pmode(logic h);
        @(negedge core_clk) halt = h;
        sleepI = 1;
        @(negedge core_clk) sleepI = 0;
    endtask
    task automatic wakeUp;
        @(negedge core_clk) wake = 1;
        @(negedge core_clk) wake = 0;
        @(negedge core_clk);
    endtask
    // Bounded wait for the handover to finish
    task automatic waitSel(pmc_sel_e e);
        for (cyc = 0; sel !== e && cyc < 1000; cyc++) @(negedge core_clk);
        chk("deviceClockSel", e, sel);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge core_clk);
        resetn = 1;
        for (cyc = 0; rstOut !== 1'b1 && cyc < 1000; cyc++) @(negedge core_clk);
        // First primary rise counts at once, so 16 rises span 15 periods of 8 cycles
        chk("reset span", 1, cyc >= 15 * 8 + 40);
        chk("primary ready", 1, ready);
        pmode(0);
        chk("inSleep", 1, inS);
        chk("clock enables", 0, {cpuEn, perEn});
        chk("primary enable", 0, oscEn.primaryEn);
        chk("slow enable", 1, oscEn.slowIntEn);
        chk("sleep pins", 0, |pins);
        @(negedge core_clk) chk("ready in sleep", 0, ready);
        wakeUp();
        pmode(1);
        chk("inIdle", 1, inI);
        chk("clock enables", 1, {cpuEn, perEn});
        chk("primary enable", 1, oscEn.primaryEn);
        wakeUp();
        choice = 2'h1;
        repeat (60) @(negedge core_clk);
        chk("refused select", PMC_SEL_PRIMARY, sel);
        secEn = 1;
        waitSel(PMC_SEL_SECONDARY);
        chk("secondary run flag", 1, secRun);
        choice = 2'h2;
        post = 1;
        waitSel(PMC_SEL_FAST_INT);
        chk("postscaler", 1, fvp);
        chk("fast stable flag", 1, fastOk);
        post = 0;
        waitSel(PMC_SEL_SLOW_INT);
        chk("fast enable", 0, oscEn.fastIntEn);
        choice = 2'h3;
        repeat (60) @(negedge core_clk);
        chk("low bit ignored", PMC_SEL_SLOW_INT, sel);
        choice = 2'h0;
        waitSel(PMC_SEL_PRIMARY);
        conclude();
    end
    initial begin
        #100000 errors++;
        conclude();
    end
endmodule // testbench
